// File: cfg_bank_cfg.svh
// Offsets, reset values, field positions and write masks for the configuration bank slice
// Included by the design modules; definitions only
`ifndef CFG_BANK_CFG_SVH
`define CFG_BANK_CFG_SVH

`define IDX_DRIVE_TYPE 8'h06
`define IDX_POWER_BOOT 8'h07
`define IDX_DEC_LOW 8'h08
`define IDX_DEC_HIGH 8'h09
`define IDX_THR_IR 8'h0a

`define RST_DRIVE_TYPE 8'hff
`define RST_POWER_BOOT 8'h00
`define RST_DEC_LOW 8'h00
`define RST_DEC_HIGH 8'h00
`define RST_THR_IR 8'h00

`define MASK_POWER_BOOT 8'hf3
`define MASK_DEC_LOW 8'hf0
`define MASK_DEC_HIGH 8'hcf
`define MASK_THR_IR 8'hcf

`define BOOT_BIT 0
`define PD_PAR_BIT 4
`define PD_UART2_BIT 5
`define PD_UART1_BIT 6
`define PD_FLOPPY_BIT 7
`define DEC_CFG_MSB 7
`define DEC_CFG_LSB 6
`define IR_ROUTE_MSB 7
`define IR_ROUTE_LSB 6

`endif

// File: cfg_bank_pkg.sv
// Types shared by the configuration bank slice
// Assumes cfg_bank_cfg.svh holds the numeric constants
package cfg_bank_pkg;
  typedef enum logic [1:0] {
    DEC_OFF = 2'h0,
    DEC_ONE_BYTE = 2'h1,
    DEC_EIGHT_BYTE = 2'h2,
    DEC_SIXTEEN_BYTE = 2'h3
  } decode_mode_t;

  typedef enum logic [1:0] {
    IR_PRIMARY = 2'h0,
    IR_SECONDARY = 2'h1,
    IR_RESERVED = 2'h2,
    IR_OUTPUTS_OFF = 2'h3
  } ir_route_t;
endpackage

// File: general_address_decoder.sv
// Programmable I/O address decoder with active-low registered select
// Assumes the host address is synchronous to core_clk_i
`timescale 1ns/1ps
`include "cfg_bank_cfg.svh"
module general_address_decoder (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Programmed match
  input wire logic [7:0] match_i,
  input wire cfg_bank_pkg::decode_mode_t mode_i,
  // Host address
  input wire logic [15:0] addr_i,
  // Select
  output logic general_decode_select_n_o
);
  import cfg_bank_pkg::*;

  logic hit;

  always_comb
  begin
    hit = 1'b0;
    if ((addr_i[15:12] == 4'h0) && (addr_i[11:4] == match_i))
    begin
      unique case (mode_i)
        DEC_OFF: hit = 1'b0;
        DEC_ONE_BYTE: hit = (addr_i[3:0] == 4'h0);
        DEC_EIGHT_BYTE: hit = ~addr_i[3];
        DEC_SIXTEEN_BYTE: hit = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      general_decode_select_n_o <= 1'b1;
    else
      general_decode_select_n_o <= ~hit;
  end
endmodule

// File: infrared_pin_route.sv
// Routes the active infrared function to one of two pin pairs
// Assumes transmit data and receive pins are synchronous to core_clk_i
`timescale 1ns/1ps
`include "cfg_bank_cfg.svh"
module infrared_pin_route (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Route select
  input wire cfg_bank_pkg::ir_route_t route_i,
  // Infrared function side
  input wire logic ir_tx_i,
  output logic ir_rx_o,
  // Pins
  input wire logic primary_ir_receive_pin_i,
  input wire logic secondary_ir_receive_pin_i,
  output logic primary_ir_transmit_pin_o,
  output logic primary_ir_transmit_pin_oe_o,
  output logic secondary_ir_transmit_pin_o,
  output logic secondary_ir_transmit_pin_oe_o
);
  import cfg_bank_pkg::*;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      primary_ir_transmit_pin_o <= 1'b0;
      primary_ir_transmit_pin_oe_o <= 1'b1;
      secondary_ir_transmit_pin_o <= 1'b0;
      secondary_ir_transmit_pin_oe_o <= 1'b0;
      ir_rx_o <= 1'b0;
    end
    else
    begin
      primary_ir_transmit_pin_o <= (route_i == IR_PRIMARY) ? ir_tx_i : 1'b0;
      secondary_ir_transmit_pin_o <= (route_i == IR_SECONDARY) ? ir_tx_i : 1'b0;
      // Reserved code drives like the off code so no pin is left undefined
      primary_ir_transmit_pin_oe_o <= (route_i == IR_PRIMARY);
      secondary_ir_transmit_pin_oe_o <= (route_i == IR_SECONDARY);
      unique case (route_i)
        IR_PRIMARY: ir_rx_o <= primary_ir_receive_pin_i;
        IR_SECONDARY: ir_rx_o <= secondary_ir_receive_pin_i;
        IR_RESERVED: ir_rx_o <= 1'b0;
        IR_OUTPUTS_OFF: ir_rx_o <= 1'b0;
      endcase
    end
  end
endmodule

// File: config_regs_drive_power_decode.sv
// Configuration registers 06h to 0ah: drive types, boot and power-down, decoder, threshold and IR routing
// Assumes an outside configuration port supplies the state flag, index and read/write strobes
//
// Functional notes
// - Drive-type register reachable only in configuration state with index 06h.
// - Drive-type register resets to ffh; two bits per drive slot.
// - Power/boot register at index 07h, configuration state only, resets 00h.
// - Boot field: 0 selects drive A, 1 selects drive B.
// - Bits 4..7 enable auto power-down for parallel, UART2, UART1, floppy.
// - Power-down enables clear on power-on or hardware reset.
// - Low decoder register at index 08h, configuration state only, resets 00h.
// - Low decoder register holds address bits 7:4; low nibble reads zero.
// - High decoder register at index 09h, configuration state only, resets 00h.
// - High decoder register holds address bits 11:8 and mode in 7:6.
// - Select only when address 11:4 matches and 15:12 are zero.
// - Mode 00 off, 01 one byte, 10 eight bytes, 11 sixteen.
// - Threshold/IR register at index 0ah, configuration state only, resets 00h.
// - Low four bits set the ECP FIFO threshold.
// - Bits 5:4 ignore writes and read as zero.
// - IR route: 00 primary pins, 01 secondary, 11 both transmitters floating.
// - IR route returns to default on any reset.
// - Reserved bits are read only and read as zero.
`timescale 1ns/1ps
`include "cfg_bank_cfg.svh"
module config_regs_drive_power_decode (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Configuration access
  input wire logic cfg_state_i,
  input wire logic [7:0] config_index_register_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // Host address for the decoder
  input wire logic [15:0] host_addr_i,
  output logic general_decode_select_n_o,
  // Control outputs
  output logic [7:0] drive_type_code_o,
  output logic boot_drive_b_o,
  output logic [3:0] auto_power_down_en_o,
  output logic [3:0] ecp_threshold_field_o,
  output cfg_bank_pkg::ir_route_t infrared_pin_route_o,
  // Infrared function side
  input wire logic ir_tx_i,
  output logic ir_rx_o,
  // Infrared pins
  input wire logic primary_ir_receive_pin_i,
  input wire logic secondary_ir_receive_pin_i,
  output logic primary_ir_transmit_pin_o,
  output logic primary_ir_transmit_pin_oe_o,
  output logic secondary_ir_transmit_pin_o,
  output logic secondary_ir_transmit_pin_oe_o
);
  import cfg_bank_pkg::*;

  logic [7:0] drive_type_ids_reg;
  logic [7:0] power_down_boot_select_reg;
  logic [7:0] decode_addr_low_reg;
  logic [7:0] decode_addr_high_cfg_reg;
  logic [7:0] fifo_threshold_ir_route_reg;
  logic [7:0] rdata_next;

  // Write strobe for a given index, gated by configuration state
  function automatic logic sel_wr(input logic st, input logic wr, input logic [7:0] idx, input logic [7:0] want);
    sel_wr = st & wr & (idx == want);
  endfunction

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      drive_type_ids_reg <= `RST_DRIVE_TYPE;
    else if (sel_wr(cfg_state_i, cfg_wr_i, config_index_register_i, `IDX_DRIVE_TYPE))
      drive_type_ids_reg <= cfg_wdata_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      power_down_boot_select_reg <= `RST_POWER_BOOT;
    else if (sel_wr(cfg_state_i, cfg_wr_i, config_index_register_i, `IDX_POWER_BOOT))
      power_down_boot_select_reg <= cfg_wdata_i & `MASK_POWER_BOOT;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      decode_addr_low_reg <= `RST_DEC_LOW;
    else if (sel_wr(cfg_state_i, cfg_wr_i, config_index_register_i, `IDX_DEC_LOW))
      decode_addr_low_reg <= cfg_wdata_i & `MASK_DEC_LOW;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      decode_addr_high_cfg_reg <= `RST_DEC_HIGH;
    else if (sel_wr(cfg_state_i, cfg_wr_i, config_index_register_i, `IDX_DEC_HIGH))
      decode_addr_high_cfg_reg <= cfg_wdata_i & `MASK_DEC_HIGH;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      fifo_threshold_ir_route_reg <= `RST_THR_IR;
    else if (sel_wr(cfg_state_i, cfg_wr_i, config_index_register_i, `IDX_THR_IR))
      fifo_threshold_ir_route_reg <= cfg_wdata_i & `MASK_THR_IR;
  end

  always_comb
  begin
    rdata_next = 8'h00;
    if (cfg_state_i)
    begin
      unique case (config_index_register_i)
        `IDX_DRIVE_TYPE: rdata_next = drive_type_ids_reg;
        `IDX_POWER_BOOT: rdata_next = power_down_boot_select_reg;
        `IDX_DEC_LOW: rdata_next = decode_addr_low_reg;
        `IDX_DEC_HIGH: rdata_next = decode_addr_high_cfg_reg;
        `IDX_THR_IR: rdata_next = fifo_threshold_ir_route_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cfg_rdata_o <= 8'h00;
      cfg_rvalid_o <= 1'b0;
    end
    else
    begin
      cfg_rvalid_o <= cfg_rd_i & cfg_state_i;
      if (cfg_rd_i)
        cfg_rdata_o <= rdata_next;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      drive_type_code_o <= `RST_DRIVE_TYPE;
      boot_drive_b_o <= 1'b0;
      auto_power_down_en_o <= 4'h0;
      ecp_threshold_field_o <= 4'h0;
      infrared_pin_route_o <= IR_PRIMARY;
    end
    else
    begin
      drive_type_code_o <= drive_type_ids_reg;
      boot_drive_b_o <= power_down_boot_select_reg[`BOOT_BIT];
      auto_power_down_en_o <= power_down_boot_select_reg[`PD_FLOPPY_BIT:`PD_PAR_BIT];
      ecp_threshold_field_o <= fifo_threshold_ir_route_reg[3:0];
      infrared_pin_route_o <= ir_route_t'(fifo_threshold_ir_route_reg[`IR_ROUTE_MSB:`IR_ROUTE_LSB]);
    end
  end

  general_address_decoder u_decoder (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .match_i({decode_addr_high_cfg_reg[3:0], decode_addr_low_reg[7:4]}),
    .mode_i(decode_mode_t'(decode_addr_high_cfg_reg[`DEC_CFG_MSB:`DEC_CFG_LSB])),
    .addr_i(host_addr_i),
    .general_decode_select_n_o(general_decode_select_n_o)
  );

  infrared_pin_route u_ir_route (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .route_i(ir_route_t'(fifo_threshold_ir_route_reg[`IR_ROUTE_MSB:`IR_ROUTE_LSB])),
    .ir_tx_i(ir_tx_i),
    .ir_rx_o(ir_rx_o),
    .primary_ir_receive_pin_i(primary_ir_receive_pin_i),
    .secondary_ir_receive_pin_i(secondary_ir_receive_pin_i),
    .primary_ir_transmit_pin_o(primary_ir_transmit_pin_o),
    .primary_ir_transmit_pin_oe_o(primary_ir_transmit_pin_oe_o),
    .secondary_ir_transmit_pin_o(secondary_ir_transmit_pin_o),
    .secondary_ir_transmit_pin_oe_o(secondary_ir_transmit_pin_oe_o)
  );
endmodule

// File: config_regs_assertions.sv
// Concurrent checks on the configuration bank ports
// Bound to the top module; single clock domain
`timescale 1ns/1ps
module config_regs_assertions (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register access
  input wire logic cfg_state_i,
  input wire logic [7:0] config_index_register_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic cfg_rvalid_o,
  // Decoder and drive types
  input wire logic [15:0] host_addr_i,
  input wire logic general_decode_select_n_o,
  input wire logic [7:0] drive_type_code_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence rd_s;
    cfg_rd_i && cfg_state_i;
  endsequence
  sequence wr06_s;
    cfg_wr_i && cfg_state_i && config_index_register_i == 8'h06;
  endsequence
  a_read_answer:
    assert property (rd_s |=> cfg_rvalid_o) else $error("read not answered");
  a_valid_cause:
    assert property (cfg_rvalid_o |-> $past(cfg_rd_i && cfg_state_i)) else $error("stray read valid");
  a_refused_read:
    assert property (cfg_rd_i && !cfg_state_i |=> !cfg_rvalid_o && cfg_rdata_o == 8'h00) else $error("read leak");
  a_dec_low_zero:
    assert property (rd_s ##0 config_index_register_i == 8'h08 |=> cfg_rdata_o[3:0] == 4'h0) else $error("low nibble");
  a_thr_rsvd_zero:
    assert property (rd_s ##0 config_index_register_i == 8'h0a |=> cfg_rdata_o[5:4] == 2'h0) else $error("thr bits");
  a_pwr_rsvd_zero:
    assert property (rd_s ##0 config_index_register_i == 8'h07 |=> cfg_rdata_o[3:2] == 2'h0) else $error("pwr bits");
  a_high_addr_off:
    assert property (host_addr_i[15:12] != 4'h0 |=> general_decode_select_n_o) else $error("select on high addr");
  a_drive_mirror:
    assert property (wr06_s ##1 !(cfg_wr_i && cfg_state_i && config_index_register_i == 8'h06)
      |=> drive_type_code_o == $past(cfg_wdata_i, 2)) else $error("drive copy");
endmodule

// File: host_cfg_model.sv
// Host side of the configuration port: state flag, index, strobes, data
// Runs on the bench clock; the bench calls its tasks
`timescale 1ns/1ps
module host_cfg_model (
  // Clock
  input wire logic core_clk_i,
  // Answer
  input wire logic [7:0] cfg_rdata_i,
  input wire logic cfg_rvalid_i,
  // Requests
  output logic cfg_state_o,
  output logic [7:0] index_o,
  output logic cfg_wr_o,
  output logic cfg_rd_o,
  output logic [7:0] cfg_wdata_o
);
  initial
  begin
    cfg_state_o = 1'b0;
    index_o = 8'h00;
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    cfg_wdata_o = 8'h00;
  end
  task automatic wr(input logic s, input logic [7:0] i, input logic [7:0] d);
    @(posedge core_clk_i);
    cfg_state_o <= s;
    index_o <= i;
    cfg_wr_o <= 1'b1;
    cfg_wdata_o <= d;
    @(posedge core_clk_i);
    cfg_wr_o <= 1'b0;
    // Released data bus shows no stale value
    cfg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic s, input logic [7:0] i, output logic [7:0] d);
    int n;
    @(posedge core_clk_i);
    cfg_state_o <= s;
    index_o <= i;
    cfg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    cfg_rd_o <= 1'b0;
    #1;
    for (n = 0; s && cfg_rvalid_i !== 1'b1 && n < 4; n++)
    begin
      @(posedge core_clk_i);
      #1;
    end
    d = (n < 4) ? cfg_rdata_i : 8'hxx;
  endtask
endmodule

// File: config_regs_drive_power_decode_tb.sv
// Self-checking bench for the configuration bank slice
// Host model drives the port; bench drives decoder address and infrared pins
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module config_regs_drive_power_decode_tb;
  import cfg_bank_pkg::*;
  logic core_clk_i = 0, rst_i = 1, cfg_state_i, cfg_wr_i, cfg_rd_i, cfg_rvalid_o, general_decode_select_n_o;
  logic ir_tx_i = 0, ir_rx_o, primary_ir_receive_pin_i = 0, secondary_ir_receive_pin_i = 0, boot_drive_b_o;
  logic primary_ir_transmit_pin_o, primary_ir_transmit_pin_oe_o, secondary_ir_transmit_pin_o;
  logic secondary_ir_transmit_pin_oe_o;
  logic [7:0] config_index_register_i, cfg_wdata_i, cfg_rdata_o, drive_type_code_o, d;
  logic [3:0] auto_power_down_en_o, ecp_threshold_field_o;
  logic [15:0] host_addr_i = 16'h0000;
  ir_route_t infrared_pin_route_o;
  logic [7:0] m [6:10];
  int compares = 0;
  int miscompares = 0;
  always #25 core_clk_i = ~core_clk_i;
  host_cfg_model host (.core_clk_i(core_clk_i), .cfg_rdata_i(cfg_rdata_o), .cfg_rvalid_i(cfg_rvalid_o),
    .cfg_state_o(cfg_state_i), .index_o(config_index_register_i), .cfg_wr_o(cfg_wr_i), .cfg_rd_o(cfg_rd_i),
    .cfg_wdata_o(cfg_wdata_i));
  config_regs_drive_power_decode dut (.*);
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic s, input logic [7:0] i, input logic [7:0] v);
    host.wr(s, i, v);
    if (s && i >= 8'h06 && i <= 8'h0a)
      m[i] = v & (i == 8'h06 ? 8'hff : i == 8'h07 ? 8'hf3 : i == 8'h08 ? 8'hf0 : 8'hcf);
  endtask
  task automatic rdc(input logic s, input logic [7:0] i, input logic [7:0] e);
    host.rd(s, i, d);
    if (d === 8'hxx)
    begin
      miscompares++;
      test_done();
    end
    else
      `CHK(d, e)
  endtask
  task automatic ctl();
    repeat (2) @(posedge core_clk_i);
    #1;
    `CHK(drive_type_code_o, m[6])
    `CHK(boot_drive_b_o, m[7][0])
    `CHK(auto_power_down_en_o, m[7][7:4])
    `CHK(ecp_threshold_field_o, m[10][3:0])
    `CHK(infrared_pin_route_o, ir_route_t'(m[10][7:6]))
  endtask
  task automatic dec(input logic [15:0] a);
    logic hit;
    hit = a[15:12] == 4'h0 && a[11:4] == {m[9][3:0], m[8][7:4]};
    if (m[9][7:6] == 2'h0)
      hit = 1'b0;
    else if (m[9][7:6] == 2'h1)
      hit = hit && a[3:0] == 4'h0;
    else if (m[9][7:6] == 2'h2)
      hit = hit && !a[3];
    @(posedge core_clk_i);
    host_addr_i <= a;
    @(posedge core_clk_i);
    #1;
    `CHK(general_decode_select_n_o, !hit)
  endtask
  task automatic irc(input logic [1:0] c);
    wr(1, 8'h0a, {c, 6'h05});
    repeat (4)
    begin
      @(posedge core_clk_i);
      ir_tx_i <= 1'($urandom);
      primary_ir_receive_pin_i <= 1'($urandom);
      secondary_ir_receive_pin_i <= 1'($urandom);
      @(posedge core_clk_i);
      #1;
      `CHK(primary_ir_transmit_pin_oe_o, c == 2'h0)
      `CHK(secondary_ir_transmit_pin_oe_o, c == 2'h1)
      if (c < 2'h2)
        `CHK(c[0] ? secondary_ir_transmit_pin_o : primary_ir_transmit_pin_o, ir_tx_i)
      `CHK(ir_rx_o, c == 2'h0 ? primary_ir_receive_pin_i : c == 2'h1 && secondary_ir_receive_pin_i)
    end
  endtask
  initial
  begin
    int i;
    void'($urandom(15));
    m = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (i = 6; i <= 10; i++)
      rdc(1, 8'(i), m[i]);
    ctl();
    for (i = 6; i <= 10; i++)
    begin
      wr(1, 8'(i), 8'hff);
      rdc(1, 8'(i), m[i]);
    end
    repeat (20)
    begin
      i = 6 + $urandom % 5;
      wr(1, 8'(i), 8'($urandom));
      rdc(1, 8'(i), m[i]);
    end
    ctl();
    wr(0, 8'h06, 8'h5a);
    wr(1, 8'h0b, 8'h3c);
    rdc(0, 8'h06, 8'h00);
    rdc(1, 8'h0b, 8'h00);
    rdc(1, 8'h06, m[6]);
    $display("register access done");
    for (int c = 0; c < 4; c++)
    begin
      wr(1, 8'h08, 8'($urandom));
      wr(1, 8'h09, {2'(c), 6'($urandom)});
      for (int a = 0; a < 6; a++)
        dec({4'h0, m[9][3:0], m[8][7:4], 4'(a * 3)});
      dec({4'h1, m[9][3:0], m[8][7:4], 4'h0});
      dec(16'($urandom));
    end
    $display("decoder done");
    for (int c = 0; c < 4; c++)
      irc(2'(c));
    $display("infrared routing done");
    wr(1, 8'h07, 8'hf1);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    m = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    ctl();
    rdc(1, 8'h07, m[7]);
    rdc(1, 8'h0a, m[10]);
    $display("second reset done");
    test_done();
  end
endmodule
bind config_regs_drive_power_decode config_regs_assertions chk (.*);
